// >>> include/brs_defs.vh
// Purpose: constants of the brake release sequencer
// Assumes: 50 MHz clock, wait times in 0.01 s steps, frequency in 0.01 Hz
// Notes: counts are derived from times and the clock rate
//
// Summary of operation
// - brake mode off, on with dc, on without
// - run command accelerates to release frequency
// - wait release time, then assert release output
// - current below release level trips with error
// - confirm assigned: hold, await confirm, else trip
// - confirm unassigned: skip wait, go accelerate wait
// - wait acceleration time, then accelerate to command
// - run removed: decelerate to braking frequency, release off
// - confirm must stay off confirm time, else trip
// - confirm unassigned: skip off check at stop
// - wait stopping time, then decelerate to zero
// - release and error outputs assignable to terminals
// - position control: apply brake after positioning done
`ifndef BRS_DEFS_VH
`define BRS_DEFS_VH

// ----------------------------------------------------------------
// brake mode selection
// ----------------------------------------------------------------
`define BRS_MODE_OFF 2'h0
`define BRS_MODE_DC 2'h1
`define BRS_MODE_NODC 2'h2

// ----------------------------------------------------------------
// limits and timing
// ----------------------------------------------------------------
`define BRS_FREQ_MAX 16'h9C40
`define BRS_WAIT_MAX 9'h1F4
`define BRS_CUR_MAX 9'h140
`define BRS_CONFIRM_CODE 7'h2C
`define BRS_ERROR_CODE 7'h14
`define BRS_RELEASE_CODE 7'h13
`define BRS_CLK_HZ 50000000
`define BRS_TICK_HZ 100
`define BRS_TICK_CYC (`BRS_CLK_HZ / `BRS_TICK_HZ)

`endif

// >>> logic/brs_sequencer.v
// Purpose: brake release sequencer of a motor drive
// Assumes: frequency in 0.01 Hz, current in 0.01 x rated current
// Notes: frequency target goes to the ramp generator outside

`timescale 1ns/100ps
`include "brs_defs.vh"

module brs_sequencer (
  // clock and reset
  input wire mclk_i,
  input wire rst_b_i,
  // configuration
  input wire [1:0] brake_mode_i,
  input wire [15:0] release_freq_i,
  input wire [15:0] braking_freq_i,
  input wire [8:0] release_cur_i,
  input wire [8:0] wait_release_i,
  input wire [8:0] wait_accel_i,
  input wire [8:0] wait_stop_i,
  input wire [8:0] wait_confirm_i,
  input wire [6:0] in_func_i,
  input wire [6:0] out_func_i,
  // drive status
  input wire run_cmd_i,
  input wire [15:0] cmd_freq_i,
  input wire [15:0] out_freq_i,
  input wire [8:0] out_cur_i,
  input wire pos_ctrl_i,
  input wire pos_done_i,
  input wire brake_confirm_input_i,
  // outputs
  output reg [15:0] freq_target_o,
  output reg drive_on_o,
  output reg trip_o,
  output reg brake_release_output_o,
  output reg brake_error_output_o,
  output reg out_term_o,
  output reg [3:0] state_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 4'h0;
  localparam ST_ACC_REL = 4'h1;
  localparam ST_WAIT_REL = 4'h2;
  localparam ST_CONFIRM = 4'h3;
  localparam ST_WAIT_ACC = 4'h4;
  localparam ST_RUN = 4'h5;
  localparam ST_DEC_BRK = 4'h6;
  localparam ST_CONF_OFF = 4'h7;
  localparam ST_WAIT_STOP = 4'h8;
  localparam ST_DEC_ZERO = 4'h9;
  localparam ST_TRIP = 4'hA;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [25:0] tick_cnt;
  reg tick;
  reg [8:0] wait_cnt;
  reg clr_wait;
  reg [15:0] next_freq;
  reg next_rel;
  reg confirm_q;
  wire enabled;
  wire confirm_used;
  wire expired_rel;
  wire expired_acc;
  wire expired_stop;
  wire expired_conf;

  assign enabled = (brake_mode_i == `BRS_MODE_DC) ||
                   (brake_mode_i == `BRS_MODE_NODC);
  assign confirm_used = (in_func_i == `BRS_CONFIRM_CODE);
  assign expired_rel = (wait_cnt >= wait_release_i);
  assign expired_acc = (wait_cnt >= wait_accel_i);
  assign expired_stop = (wait_cnt >= wait_stop_i);
  assign expired_conf = (wait_cnt >= wait_confirm_i);

  // ----------------------------------------------------------------
  // 0.01 s timebase and wait counter
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 26'h0;
      tick <= 1'b0;
      wait_cnt <= 9'h000;
    end else begin
      // the timebase restarts with each wait so every wait is exact
      if (clr_wait || tick_cnt == `BRS_TICK_CYC - 1) begin
        tick_cnt <= 26'h0;
      end else begin
        tick_cnt <= tick_cnt + 26'h1;
      end
      tick <= !clr_wait && (tick_cnt == `BRS_TICK_CYC - 1);
      if (clr_wait) begin
        wait_cnt <= 9'h000;
      end else if (tick && wait_cnt != 9'h1FF) begin
        wait_cnt <= wait_cnt + 9'h001;
      end
    end
  end

  // last cycle's contact level, to find where the contact opens
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      confirm_q <= 1'b0;
    end else begin
      confirm_q <= brake_confirm_input_i;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    clr_wait = 1'b0;
    case (state)
      ST_IDLE: begin
        clr_wait = 1'b1;
        if (run_cmd_i && enabled) begin
          next_state = ST_ACC_REL;
        end
      end
      ST_ACC_REL: begin
        clr_wait = 1'b1;
        if (!run_cmd_i) begin
          next_state = ST_DEC_ZERO;
        end else if (out_freq_i >= release_freq_i) begin
          next_state = ST_WAIT_REL;
        end
      end
      ST_WAIT_REL: begin
        if (expired_rel) begin
          clr_wait = 1'b1;
          if (out_cur_i < release_cur_i) begin
            next_state = ST_TRIP;
          end else if (confirm_used) begin
            next_state = ST_CONFIRM;
          end else begin
            next_state = ST_WAIT_ACC;
          end
        end
      end
      ST_CONFIRM: begin
        if (brake_confirm_input_i) begin
          clr_wait = 1'b1;
          next_state = ST_WAIT_ACC;
        end else if (expired_conf) begin
          next_state = ST_TRIP;
        end
      end
      ST_WAIT_ACC: begin
        if (expired_acc) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        clr_wait = 1'b1;
        if (!run_cmd_i) begin
          next_state = ST_DEC_BRK;
        end
      end
      ST_DEC_BRK: begin
        clr_wait = 1'b1;
        // under position control the brake waits for positioning end
        if (pos_ctrl_i ? pos_done_i : (out_freq_i <= braking_freq_i)) begin
          next_state = confirm_used ? ST_CONF_OFF : ST_WAIT_STOP;
        end
      end
      ST_CONF_OFF: begin
        if (brake_confirm_input_i) begin
          // still closed once the window since release dropped: trip
          if (expired_conf) begin
            next_state = ST_TRIP;
          end
        end else if (confirm_q) begin
          // contact just opened: the off span is timed from here
          clr_wait = 1'b1;
        end else if (expired_conf) begin
          clr_wait = 1'b1;
          next_state = ST_WAIT_STOP;
        end
      end
      ST_WAIT_STOP: begin
        if (expired_stop) begin
          next_state = ST_DEC_ZERO;
        end
      end
      ST_DEC_ZERO: begin
        clr_wait = 1'b1;
        if (out_freq_i == 16'h0000) begin
          next_state = ST_IDLE;
        end
      end
      ST_TRIP: begin
        clr_wait = 1'b1;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // release and frequency target follow the state being entered
  always @* begin
    next_rel = 1'b0;
    next_freq = 16'h0000;
    case (next_state)
      ST_ACC_REL, ST_WAIT_REL: begin
        next_freq = release_freq_i;
      end
      ST_CONFIRM, ST_WAIT_ACC: begin
        next_rel = 1'b1;
        next_freq = release_freq_i;
      end
      ST_RUN: begin
        next_rel = 1'b1;
        next_freq = cmd_freq_i;
      end
      ST_DEC_BRK: begin
        next_rel = 1'b1;
        next_freq = braking_freq_i;
      end
      ST_CONF_OFF, ST_WAIT_STOP: begin
        next_freq = braking_freq_i;
      end
      default: begin
        next_freq = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      freq_target_o <= 16'h0000;
      drive_on_o <= 1'b0;
      trip_o <= 1'b0;
      brake_release_output_o <= 1'b0;
      brake_error_output_o <= 1'b0;
      out_term_o <= 1'b0;
      state_o <= ST_IDLE;
    end else begin
      state <= next_state;
      state_o <= next_state;
      freq_target_o <= next_freq;
      drive_on_o <= (next_state != ST_IDLE) && (next_state != ST_TRIP);
      trip_o <= (next_state == ST_TRIP);
      brake_error_output_o <= (next_state == ST_TRIP);
      brake_release_output_o <= next_rel;
      // terminal mapping of the two brake signals
      if (out_func_i == `BRS_ERROR_CODE) begin
        out_term_o <= (next_state == ST_TRIP);
      end else if (out_func_i == `BRS_RELEASE_CODE) begin
        out_term_o <= next_rel;
      end else begin
        out_term_o <= 1'b0;
      end
    end
  end

endmodule

// >>> testbench/brs_brake_model.sv
// Purpose: external brake with a release feedback contact
// Assumes: contact closes while the brake is released
// Notes: stuck_i models a jammed brake that never opens,
// closed_i a welded contact that reads released unless stuck_i is set
`timescale 1ns/100ps
module brs_brake_model (
  // brake side
  input wire release_i,
  input wire stuck_i,
  input wire closed_i,
  output wire confirm_o
);
  // prompt contact only, since zero waits leave no slack for a slow one
  assign confirm_o = (release_i | closed_i) & !stuck_i;
endmodule

// >>> testbench/brs_sequencer_monitor.sv
// Purpose: port assertions of the brake release sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes: none
`timescale 1ns/100ps
module brs_sequencer_monitor (
  // clock, reset and inputs
  input wire mclk_i,
  input wire rst_b_i,
  input wire [1:0] brake_mode_i,
  input wire [15:0] release_freq_i,
  input wire [15:0] braking_freq_i,
  input wire [8:0] release_cur_i,
  input wire [6:0] in_func_i,
  input wire run_cmd_i,
  input wire [8:0] out_cur_i,
  // outputs
  input wire [15:0] freq_target_o,
  input wire drive_on_o,
  input wire trip_o,
  input wire brake_release_output_o,
  input wire brake_error_output_o,
  input wire [3:0] state_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  mode_off_a: assert property (
    state_o == 4'h0 && brake_mode_i == 2'h0 |=> state_o == 4'h0)
    else $error("run taken while off");
  run_start_a: assert property (
    state_o == 4'h0 && run_cmd_i && brake_mode_i inside {2'h1, 2'h2}
    |=> state_o == 4'h1 && drive_on_o
    && freq_target_o == $past(release_freq_i)) else $error("bad start");
  rel_cur_a: assert property (
    $rose(brake_release_output_o) |-> $past(out_cur_i) >=
    $past(release_cur_i)) else $error("release under current");
  err_latch_a: assert property (
    brake_error_output_o |=> brake_error_output_o && trip_o)
    else $error("error not latched");
  run_rel_a: assert property (
    state_o == 4'h5 |-> brake_release_output_o && drive_on_o)
    else $error("run without release");
  dec_brk_a: assert property (
    state_o == 4'h6 |-> freq_target_o == braking_freq_i)
    else $error("bad braking target");
  stop_zero_a: assert property (
    state_o == 4'h9 |-> !brake_release_output_o && freq_target_o == 0)
    else $error("bad stop ramp");
  skip_conf_a: assert property (
    $rose(brake_release_output_o) && in_func_i != 7'h2C
    |-> state_o == 4'h4) else $error("confirm not skipped");
  cover property (state_o == 4'hA);
  cover property (state_o == 4'h5);
  cover property (state_o == 4'h9);
endmodule
bind brs_sequencer brs_sequencer_monitor u_mon (.mclk_i, .rst_b_i,
  .brake_mode_i, .release_freq_i, .braking_freq_i, .release_cur_i,
  .in_func_i, .run_cmd_i, .out_cur_i, .freq_target_o, .drive_on_o,
  .trip_o, .brake_release_output_o, .brake_error_output_o, .state_o);

// >>> testbench/testbench.sv
// Purpose: random and corner runs of the brake release sequencer
// Assumes: all waits zero, since one timer tick is far too long
// Notes: the bench stands in for the ramp generator
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
  reg mclk_i = 0, rst_b_i = 0, run_cmd_i = 0, pos_ctrl_i = 0;
  reg pos_done_i = 1, stuck = 0, welded = 0;
  reg [1:0] brake_mode_i = 0;
  reg [15:0] release_freq_i = 0, braking_freq_i = 0, cmd_freq_i = 0;
  reg [15:0] out_freq_i = 0;
  reg [8:0] release_cur_i = 0, out_cur_i = 0;
  reg [6:0] in_func_i = 0, out_func_i = 0;
  wire [8:0] wait_release_i = 9'h000, wait_accel_i = 9'h000;
  wire [8:0] wait_stop_i = 9'h000, wait_confirm_i = 9'h000;
  wire [15:0] freq_target_o;
  wire [3:0] state_o;
  wire drive_on_o, trip_o, brake_release_output_o, brake_error_output_o;
  wire out_term_o, brake_confirm_input_i;
  int error_cnt = 0, n_checks = 0;
  logic [31:0] rs = 32'h48, r;
  brs_sequencer u_dut (.mclk_i, .rst_b_i, .brake_mode_i, .release_freq_i,
    .braking_freq_i, .release_cur_i, .wait_release_i, .wait_accel_i,
    .wait_stop_i, .wait_confirm_i, .in_func_i, .out_func_i, .run_cmd_i,
    .cmd_freq_i, .out_freq_i, .out_cur_i, .pos_ctrl_i, .pos_done_i,
    .brake_confirm_input_i, .freq_target_o, .drive_on_o, .trip_o,
    .brake_release_output_o, .brake_error_output_o, .out_term_o, .state_o);
  brs_brake_model u_brk (.release_i(brake_release_output_o),
    .stuck_i(stuck), .closed_i(welded), .confirm_o(brake_confirm_input_i));
  initial forever #10 mclk_i = ~mclk_i;
  // ramp stand-in: output frequency follows the target one edge later
  always @(posedge mclk_i) out_freq_i <= freq_target_o;
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_st(input logic [3:0] a, input logic [3:0] b);
    for (int i = 0; i < 400 && state_o !== a && state_o !== b; i++) begin
      @(posedge mclk_i);
      #1;
    end
  endtask
  // bits: 1:0 mode, 2 confirm assigned, 3 stuck, 4 low current, 5 pos,
  // 6 contact welded closed
  task automatic run_one(input logic [6:0] c);
    logic t;
    logic w;
    logic [8:0] rc;
    @(posedge mclk_i);
    rc = 9'(rnd() % 9'h140) + 9'h001;
    rst_b_i <= 0;
    run_cmd_i <= 0;
    welded <= c[6];
    brake_mode_i <= c[1:0];
    release_freq_i <= 16'(rnd() % 16'h9C40);
    braking_freq_i <= 16'(rnd() % 16'h9C40);
    cmd_freq_i <= 16'(rnd() % 16'h9C40);
    release_cur_i <= rc;
    out_cur_i <= c[4] ? rc - 9'h001 : rc;
    in_func_i <= c[2] ? 7'h2C : 7'h00;
    out_func_i <= c[0] ? 7'h14 : 7'h13;
    stuck <= c[3];
    pos_ctrl_i <= c[5];
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1;
    @(posedge mclk_i);
    run_cmd_i <= 1;
    t = c[4] || (c[2] && c[3]);
    w = c[6] && c[2];
    if (c[1:0] == 2'h0 || c[1:0] == 2'h3) begin
      repeat (20) @(posedge mclk_i);
      #1;
      `CHK(state_o, 4'h0)
    end else begin
      wait_st(4'h5, 4'hA);
      `CHK(trip_o, t)
      `CHK(brake_error_output_o, t)
      `CHK(out_term_o, c[0] ? t : !t)
      if (!t) begin
        `CHK(freq_target_o, cmd_freq_i)
        @(posedge mclk_i);
        pos_done_i <= !c[5];
        run_cmd_i <= 0;
        if (c[5]) begin
          repeat (30) @(posedge mclk_i);
          #1;
          `CHK(brake_release_output_o, 1'b1)
          @(posedge mclk_i);
          pos_done_i <= 1;
        end
        wait_st(4'h0, 4'hA);
        `CHK(state_o, w ? 4'hA : 4'h0)
        `CHK(brake_error_output_o, w)
        `CHK(brake_release_output_o, 1'b0)
      end
    end
  endtask
  initial begin
    for (int k = 0; k < 20; k++) begin
      r = k < 4 ? 32'h45190E25 >> (8 * k) : rnd();
      run_one(r[6:0]);
    end
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    test_done();
  end
endmodule
